// File: design/paovr_port_a.sv
// port a alternate-function override logic between pad control and peripherals
`timescale 1ns/1ps
module paovr_port_a
    import paovr_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // pads
    input wire logic [PAOVR_PINS-1:0] pad_din,
    // port register bits
    input wire logic [PAOVR_PINS-1:0] port_dir,
    input wire logic [PAOVR_PINS-1:0] port_out,
    input wire logic [PAOVR_PINS-1:0] port_pullup,
    input wire logic [PAOVR_PINS-1:0] state_din_en,
    // timer
    input wire logic cmp_a_drive_en,
    input wire logic cmp_a_out,
    input wire logic cmp_b_drive_en,
    input wire logic cmp_b_out,
    input wire logic alt_location_sel,
    // pin change
    input wire logic pc_group0_en,
    input wire logic [PAOVR_PINS-1:0] pc_src_en,
    // system configuration
    input wire logic reset_cfg_bit,
    input wire logic ext_clk_sel,
    input wire logic deep_sleep_state,
    input wire logic ana0_dig_off,
    input wire logic ana1_dig_off,
    input wire logic ana2_dig_off,
    input wire logic ana3_dig_off,
    // pad control
    output logic [PAOVR_PINS-1:0] pad_pullup_q,
    output logic [PAOVR_PINS-1:0] pad_drive_en_q,
    output logic [PAOVR_PINS-1:0] pad_drive_val_q,
    output logic [PAOVR_PINS-1:0] pad_din_en_q,
    // override signals per pin
    output paovr_ovr_type [PAOVR_PINS-1:0] ovr_q,
    output logic reset_pin_off_q,
    // peripheral inputs
    output logic [PAOVR_PINS-1:0] pc_level_q,
    output logic capture_in_q,
    output logic counter_src_in_q
);

    logic reset_pin_off;
    logic [PAOVR_PINS-1:0] pc_act;
    logic [PAOVR_PINS-1:0] ana_off;
    logic [PAOVR_PINS-1:0] din_level;
    logic [PAOVR_PINS-1:0] din_gated;
    logic [PAOVR_PINS-1:0] pullup_d;
    logic [PAOVR_PINS-1:0] drive_en_d;
    logic [PAOVR_PINS-1:0] drive_val_d;
    logic [PAOVR_PINS-1:0] din_en_d;
    paovr_ovr_type [PAOVR_PINS-1:0] ovr_d;

    assign reset_pin_off = (reset_cfg_bit == PAOVR_CFG_PROGRAMMED);
    assign pc_act = pc_src_en & {PAOVR_PINS{pc_group0_en}};
    assign ana_off = {1'b0, ana3_dig_off, ana2_dig_off, 3'b000, ana1_dig_off, ana0_dig_off};

    // override computation
    always_comb begin
        for (int i = 0; i < PAOVR_PINS; i++) begin
            ovr_d[i] = PAOVR_OVR_NONE;
            ovr_d[i].din_en = pc_act[i] | ana_off[i];
            ovr_d[i].din_val = pc_act[i];
        end
        // compare a sits on pin 3 only at the alternate location
        ovr_d[PAOVR_PIN_CMPA].portval_en = cmp_a_drive_en & alt_location_sel;
        ovr_d[PAOVR_PIN_CMPA].portval_val = cmp_a_out & alt_location_sel;
        ovr_d[PAOVR_PIN_CMPB_DEF].portval_en = cmp_b_drive_en & alt_location_sel;
        ovr_d[PAOVR_PIN_CMPB_DEF].portval_val = cmp_b_out & alt_location_sel;
        ovr_d[PAOVR_PIN_CMPB_ALT].portval_en = cmp_b_drive_en & alt_location_sel;
        ovr_d[PAOVR_PIN_CMPB_ALT].portval_val = cmp_b_out & alt_location_sel;
        // reset pin: pull-up value is a constant one, gated only by its enable
        ovr_d[PAOVR_PIN_RST].pullup_en = reset_pin_off;
        ovr_d[PAOVR_PIN_RST].pullup_val = PAOVR_RST_PULLUP_VAL;
        ovr_d[PAOVR_PIN_RST].dir_en = reset_pin_off;
        ovr_d[PAOVR_PIN_RST].dir_val = PAOVR_RST_DIR_VAL;
        ovr_d[PAOVR_PIN_RST].din_en = reset_pin_off | pc_act[PAOVR_PIN_RST];
        ovr_d[PAOVR_PIN_RST].din_val = reset_pin_off & pc_act[PAOVR_PIN_RST];
        // external clock pad
        ovr_d[PAOVR_PIN_CLK].pullup_en = ext_clk_sel;
        ovr_d[PAOVR_PIN_CLK].pullup_val = PAOVR_CLK_PULLUP_VAL;
        ovr_d[PAOVR_PIN_CLK].dir_en = ext_clk_sel;
        ovr_d[PAOVR_PIN_CLK].dir_val = PAOVR_CLK_DIR_VAL;
        ovr_d[PAOVR_PIN_CLK].portval_en = ext_clk_sel;
        ovr_d[PAOVR_PIN_CLK].portval_val = PAOVR_CLK_PORTVAL_VAL;
        ovr_d[PAOVR_PIN_CLK].din_en = ext_clk_sel | pc_act[PAOVR_PIN_CLK]
            | ana_off[PAOVR_PIN_CLK];
        ovr_d[PAOVR_PIN_CLK].din_val = (ext_clk_sel & deep_sleep_state)
            | (ext_clk_sel & pc_act[PAOVR_PIN_CLK]);
    end

    // apply overrides to the port register bits, one slice per pin
    genvar g;
    generate
        for (g = 0; g < PAOVR_PINS; g++) begin : g_pin
            logic base_val;
            assign pullup_d[g] = ovr_d[g].pullup_en ? ovr_d[g].pullup_val : port_pullup[g];
            assign drive_en_d[g] = ovr_d[g].dir_en ? ovr_d[g].dir_val : port_dir[g];
            // toggle is held off, so the port bit passes straight through
            assign base_val = ovr_d[g].toggle_en ? ~port_out[g] : port_out[g];
            assign drive_val_d[g] = ovr_d[g].portval_en ? ovr_d[g].portval_val : base_val;
            assign din_en_d[g] = ovr_d[g].din_en ? ovr_d[g].din_val : state_din_en[g];
        end
    endgenerate

    paovr_pad_sync #(
        .WIDTH(PAOVR_PINS)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .pad_in(pad_din),
        .level_q(din_level)
    );

    // a disabled input buffer reads low, so sleeping pins cannot raise pin changes
    assign din_gated = din_level & pad_din_en_q;

    // pad control registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pad_pullup_q <= PAOVR_RST_BYTE;
            pad_drive_en_q <= PAOVR_RST_BYTE;
            pad_drive_val_q <= PAOVR_RST_BYTE;
            pad_din_en_q <= PAOVR_RST_BYTE;
        end else if (ce) begin
            pad_pullup_q <= pullup_d;
            pad_drive_en_q <= drive_en_d;
            pad_drive_val_q <= drive_val_d;
            pad_din_en_q <= din_en_d;
        end
    end

    // override snapshot registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ovr_q <= '0;
            reset_pin_off_q <= PAOVR_RST_BIT;
        end else if (ce) begin
            ovr_q <= ovr_d;
            reset_pin_off_q <= reset_pin_off;
        end
    end

    // peripheral inputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_level_q <= PAOVR_RST_BYTE;
            capture_in_q <= PAOVR_RST_BIT;
            counter_src_in_q <= PAOVR_RST_BIT;
        end else if (ce) begin
            pc_level_q <= din_gated;
            capture_in_q <= din_gated[PAOVR_PIN_CAP];
            counter_src_in_q <= din_gated[PAOVR_PIN_CLK];
        end
    end

    // checks
    property p_cmpa_pin3;
        @(posedge clk_sys) disable iff (rst)
        $past(ce) |-> ovr_q[PAOVR_PIN_CMPA].portval_en == $past(cmp_a_drive_en & alt_location_sel)
            && ovr_q[PAOVR_PIN_CMPA].portval_val == $past(cmp_a_out & alt_location_sel);
    endproperty
    a_cmpa_pin3: assert property (p_cmpa_pin3) else $error("pin 3 compare a override wrong");

    property p_cmpb_pins;
        @(posedge clk_sys) disable iff (rst)
        $past(ce) && $past(cmp_b_drive_en) && $past(alt_location_sel) && ($past(port_dir) == 8'hff)
            |-> pad_drive_val_q[PAOVR_PIN_CMPB_DEF] == $past(cmp_b_out)
            && pad_drive_val_q[PAOVR_PIN_CMPB_ALT] == $past(cmp_b_out);
    endproperty
    a_cmpb_pins: assert property (p_cmpb_pins) else $error("compare b not driven on pins 1 and 5");

    property p_cap;
        @(posedge clk_sys) disable iff (rst)
        ce |=> capture_in_q == pc_level_q[PAOVR_PIN_CAP] && ovr_q[PAOVR_PIN_CAP].pullup_en == 1'b0
            && ovr_q[PAOVR_PIN_CAP].dir_en == 1'b0 && ovr_q[PAOVR_PIN_CAP].portval_en == 1'b0;
    endproperty
    a_cap: assert property (p_cap) else $error("capture input differs from pin 4 level");

    property p_rst_pin;
        @(posedge clk_sys) disable iff (rst)
        $past(ce) && reset_pin_off_q |-> pad_pullup_q[PAOVR_PIN_RST]
            && !pad_drive_en_q[PAOVR_PIN_RST];
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin not forced to pulled input");

    property p_rst_cfg;
        @(posedge clk_sys) disable iff (rst)
        $past(ce) |-> reset_pin_off_q == !$past(reset_cfg_bit);
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("reset disable polarity wrong");

    property p_clk_pin;
        @(posedge clk_sys) disable iff (rst)
        ce && ext_clk_sel |=> !pad_pullup_q[PAOVR_PIN_CLK]
            && !pad_drive_en_q[PAOVR_PIN_CLK] && !pad_drive_val_q[PAOVR_PIN_CLK];
    endproperty
    a_clk_pin: assert property (p_clk_pin) else $error("clock pin overrides not all zero");

    property p_clk_din;
        @(posedge clk_sys) disable iff (rst)
        $past(ce) && $past(ext_clk_sel) |-> pad_din_en_q[PAOVR_PIN_CLK]
            == $past(deep_sleep_state | pc_act[PAOVR_PIN_CLK]);
    endproperty
    a_clk_din: assert property (p_clk_din) else $error("clock pin input enable wrong");

    property p_pin7_din;
        @(posedge clk_sys) disable iff (rst)
        $past(ce) && $past(pc_act[7]) |-> pad_din_en_q[7] == 1'b1;
    endproperty
    a_pin7_din: assert property (p_pin7_din) else $error("pin 7 input not held on");

    property p_din_state;
        @(posedge clk_sys) disable iff (rst)
        $past(ce) && !$past(ovr_d[PAOVR_PIN_ANA3].din_en)
            |-> pad_din_en_q[PAOVR_PIN_ANA3] == $past(state_din_en[PAOVR_PIN_ANA3]);
    endproperty
    a_din_state: assert property (p_din_state) else $error("pin 6 input enable ignores state");

    property p_no_toggle;
        @(posedge clk_sys) disable iff (rst)
        ovr_q[0].toggle_en == 1'b0 && ovr_q[7].toggle_en == 1'b0 && ovr_q[7].dir_en == 1'b0;
    endproperty
    a_no_toggle: assert property (p_no_toggle) else $error("toggle override active");

endmodule

// File: design/paovr_pkg.sv
// shared constants and types for the port a alternate-function override block
package paovr_pkg;

    localparam int PAOVR_PINS = 8;

    // pin positions of the alternate functions
    localparam int PAOVR_PIN_CLK = 0;
    localparam int PAOVR_PIN_CMPB_DEF = 1;
    localparam int PAOVR_PIN_RST = 2;
    localparam int PAOVR_PIN_CMPA = 3;
    localparam int PAOVR_PIN_CAP = 4;
    localparam int PAOVR_PIN_CMPB_ALT = 5;
    localparam int PAOVR_PIN_ANA3 = 6;

    // synchroniser depth for pad inputs
    localparam int PAOVR_SYNC_STAGES = 3;

    // constant override values
    localparam logic PAOVR_RST_PULLUP_VAL = 1'b1;
    localparam logic PAOVR_RST_DIR_VAL = 1'b0;
    localparam logic PAOVR_CLK_PULLUP_VAL = 1'b0;
    localparam logic PAOVR_CLK_DIR_VAL = 1'b0;
    localparam logic PAOVR_CLK_PORTVAL_VAL = 1'b0;

    // configuration bit value that means programmed
    localparam logic PAOVR_CFG_PROGRAMMED = 1'b0;

    // reset values
    localparam logic [7:0] PAOVR_RST_BYTE = 8'h00;
    localparam logic PAOVR_RST_BIT = 1'b0;

    typedef struct packed {
        logic pullup_en;
        logic pullup_val;
        logic dir_en;
        logic dir_val;
        logic portval_en;
        logic portval_val;
        logic toggle_en;
        logic din_en;
        logic din_val;
    } paovr_ovr_type;

    localparam paovr_ovr_type PAOVR_OVR_NONE = '0;

endpackage

// File: design/paovr_pad_sync.sv
// three-stage pad input synchroniser with agreement filter
`timescale 1ns/1ps
module paovr_pad_sync
    import paovr_pkg::*;
#(
    parameter int WIDTH = PAOVR_PINS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // pad side
    input wire logic [WIDTH-1:0] pad_in,
    // filtered level
    output logic [WIDTH-1:0] level_q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // first stage feeds only the second
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce) begin
            s1_q <= pad_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_filt
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    level_q[g] <= 1'b0;
                end else if (ce && (s2_q[g] == s3_q[g])) begin
                    level_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate

endmodule

// File: verif/paovr_periph_model.sv
// peripheral side model: timer compare stage and the resolved pad wire
`timescale 1ns/1ps
module paovr_periph_model
    import paovr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // timer requests {a_en, a_out, b_en, b_out}
    input wire logic [3:0] cmp_req,
    output logic cmp_a_drive_en,
    output logic cmp_a_out,
    output logic cmp_b_drive_en,
    output logic cmp_b_out,
    // pad wire
    input wire logic [PAOVR_PINS-1:0] ext_en,
    input wire logic [PAOVR_PINS-1:0] ext_val,
    input wire logic [PAOVR_PINS-1:0] pad_pullup_q,
    input wire logic [PAOVR_PINS-1:0] pad_drive_en_q,
    input wire logic [PAOVR_PINS-1:0] pad_drive_val_q,
    output logic [PAOVR_PINS-1:0] pad_din
);
    logic float_q;

    // compare outputs leave the timer from a register, one cycle late
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {cmp_a_drive_en, cmp_a_out, cmp_b_drive_en, cmp_b_out} <= 4'h0;
        end else begin
            {cmp_a_drive_en, cmp_a_out, cmp_b_drive_en, cmp_b_out} <= cmp_req;
        end
    end

    // a floating pin must not read as a steady level, so it flips every cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            float_q <= 1'b0;
        end else begin
            float_q <= ~float_q;
        end
    end

    // pin driver wins over the outside world, pull-up only when nobody drives
    always_comb begin
        for (int i = 0; i < PAOVR_PINS; i++) begin
            pad_din[i] = pad_drive_en_q[i] ? pad_drive_val_q[i] :
                         ext_en[i] ? ext_val[i] : pad_pullup_q[i] ? 1'b1 : float_q;
        end
    end
endmodule

// File: verif/paovr_port_a_bench.sv
// self-checking bench for the port a override block
`timescale 1ns/1ps
`define chk(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module paovr_port_a_bench;
    import paovr_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1;
    logic [7:0] port_dir = 8'h00, port_out = 8'h00, port_pullup = 8'h00;
    logic [7:0] state_din_en = 8'h00, pc_src_en = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0] pad_din, pad_pullup_q, pad_drive_en_q, pad_drive_val_q, pad_din_en_q;
    logic [7:0] pc_level_q;
    logic [3:0] cmp_req = 4'h0;
    logic alt_location_sel = 1'b0, pc_group0_en = 1'b0, reset_cfg_bit = 1'b1;
    logic ext_clk_sel = 1'b0, deep_sleep_state = 1'b0;
    logic ana0_dig_off = 1'b0, ana1_dig_off = 1'b0, ana2_dig_off = 1'b0, ana3_dig_off = 1'b0;
    logic cmp_a_drive_en, cmp_a_out, cmp_b_drive_en, cmp_b_out;
    logic reset_pin_off_q, capture_in_q, counter_src_in_q;
    paovr_ovr_type [7:0] ovr_q;
    int mismatches = 0, n_checks = 0;

    initial forever #20 clk_sys = ~clk_sys;

    paovr_periph_model i_paovr_periph_model (.clk_sys(clk_sys), .rst(rst), .cmp_req(cmp_req),
        .cmp_a_drive_en(cmp_a_drive_en), .cmp_a_out(cmp_a_out),
        .cmp_b_drive_en(cmp_b_drive_en), .cmp_b_out(cmp_b_out), .ext_en(ext_en),
        .ext_val(ext_val), .pad_pullup_q(pad_pullup_q), .pad_drive_en_q(pad_drive_en_q),
        .pad_drive_val_q(pad_drive_val_q), .pad_din(pad_din));

    paovr_port_a i_paovr_port_a (.clk_sys(clk_sys), .rst(rst), .ce(ce), .pad_din(pad_din),
        .port_dir(port_dir), .port_out(port_out), .port_pullup(port_pullup),
        .state_din_en(state_din_en), .cmp_a_drive_en(cmp_a_drive_en), .cmp_a_out(cmp_a_out),
        .cmp_b_drive_en(cmp_b_drive_en), .cmp_b_out(cmp_b_out),
        .alt_location_sel(alt_location_sel), .pc_group0_en(pc_group0_en),
        .pc_src_en(pc_src_en), .reset_cfg_bit(reset_cfg_bit), .ext_clk_sel(ext_clk_sel),
        .deep_sleep_state(deep_sleep_state), .ana0_dig_off(ana0_dig_off),
        .ana1_dig_off(ana1_dig_off), .ana2_dig_off(ana2_dig_off), .ana3_dig_off(ana3_dig_off),
        .pad_pullup_q(pad_pullup_q), .pad_drive_en_q(pad_drive_en_q),
        .pad_drive_val_q(pad_drive_val_q), .pad_din_en_q(pad_din_en_q), .ovr_q(ovr_q),
        .reset_pin_off_q(reset_pin_off_q), .pc_level_q(pc_level_q),
        .capture_in_q(capture_in_q), .counter_src_in_q(counter_src_in_q));

    // the timer model adds a register, so three edges cover the override paths; pad reads through the synchroniser wait six
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic t_cmp;
        logic e;
        @(posedge clk_sys);
        port_dir <= 8'hff;
        port_out <= 8'h00;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys);
            alt_location_sel <= k[2];
            cmp_req <= {k[1], k[0], k[1], k[0]};
            step(3);
            e = k[1] & k[2];
            `chk(ovr_q[3].portval_en, e)
            `chk(ovr_q[3].portval_val, k[0] & k[2])
            `chk(ovr_q[5].portval_en, e)
            `chk(ovr_q[1].portval_val, k[0] & k[2])
            `chk(pad_drive_val_q[5], k[0] & e)
            `chk(pad_drive_en_q[3] & pad_drive_en_q[5], 1'b1)
            `chk(ovr_q[3].dir_en | ovr_q[5].dir_en | ovr_q[1].dir_en, 1'b0)
        end
        $display("test cmp done");
    endtask

    task automatic t_reset_pin;
        @(posedge clk_sys);
        port_dir <= 8'h04;
        port_pullup <= 8'h00;
        reset_cfg_bit <= PAOVR_CFG_PROGRAMMED;
        pc_src_en <= 8'h04;
        pc_group0_en <= 1'b1;
        step(3);
        `chk(reset_pin_off_q, 1'b1)
        `chk(pad_pullup_q[2], 1'b1)
        `chk(pad_drive_en_q[2], 1'b0)
        `chk(ovr_q[2].din_en, 1'b1)
        `chk({ovr_q[2].din_val, pad_din_en_q[2]}, 2'b11)
        @(posedge clk_sys);
        reset_cfg_bit <= ~PAOVR_CFG_PROGRAMMED;
        step(3);
        `chk(reset_pin_off_q, 1'b0)
        `chk({pad_pullup_q[2], pad_drive_en_q[2]}, 2'b01)
        `chk(pad_din_en_q[2], 1'b0)
        $display("test reset pin done");
    endtask

    task automatic t_ext_clk;
        @(posedge clk_sys);
        port_dir <= 8'h01;
        port_out <= 8'h01;
        port_pullup <= 8'h01;
        ext_clk_sel <= 1'b1;
        step(3);
        `chk({pad_pullup_q[0], pad_drive_en_q[0], pad_drive_val_q[0]}, 3'b000)
        `chk({ovr_q[0].pullup_en, ovr_q[0].dir_en, ovr_q[0].portval_en}, 3'b111)
        `chk(ovr_q[0].din_en, 1'b1)
        @(posedge clk_sys);
        ext_clk_sel <= 1'b0;
        step(3);
        `chk({pad_pullup_q[0], pad_drive_en_q[0], pad_drive_val_q[0]}, 3'b111)
        $display("test ext_clk_sel done");
    endtask

    task automatic t_pin_change;
        @(posedge clk_sys);
        port_dir <= 8'h00;
        port_pullup <= 8'h00;
        pc_src_en <= 8'hff;
        pc_group0_en <= 1'b1;
        ext_en <= 8'hff;
        ext_val <= 8'h10;
        step(3);
        for (int i = 0; i < 8; i++) begin
            `chk(ovr_q[i].din_en, 1'b1)
            `chk(ovr_q[i].toggle_en, 1'b0)
        end
        `chk(pad_din_en_q, 8'hfa)
        step(6);
        `chk(capture_in_q, 1'b1)
        `chk(pc_level_q, 8'h10)
        @(posedge clk_sys);
        pc_group0_en <= 1'b0;
        ana1_dig_off <= 1'b1;
        step(3);
        `chk(ovr_q[1].din_en, 1'b1)
        `chk(ovr_q[3].din_en, 1'b0)
        `chk(pad_din_en_q[4], 1'b0)
        $display("test pin change done");
    endtask

    task automatic t_sleep_hold;
        @(posedge clk_sys);
        state_din_en <= 8'hff;
        ext_val <= 8'h01;
        ana1_dig_off <= 1'b0;
        step(6);
        `chk(pad_din_en_q, 8'hff)
        `chk({counter_src_in_q, capture_in_q}, 2'b10)
        `chk(pc_level_q, 8'h01)
        @(posedge clk_sys);
        state_din_en <= 8'h00;
        ext_clk_sel <= 1'b1;
        deep_sleep_state <= 1'b1;
        step(3);
        `chk(pad_din_en_q, 8'h01)
        `chk(ovr_q[0].din_val, 1'b1)
        @(posedge clk_sys);
        state_din_en <= 8'hff;
        deep_sleep_state <= 1'b0;
        ana2_dig_off <= 1'b1;
        ana3_dig_off <= 1'b1;
        step(3);
        `chk(pad_din_en_q, 8'h9e)
        // a low enable must freeze every register, overrides included
        @(posedge clk_sys);
        ce <= 1'b0;
        ext_clk_sel <= 1'b0;
        ana2_dig_off <= 1'b0;
        ana3_dig_off <= 1'b0;
        step(3);
        `chk(pad_din_en_q, 8'h9e)
        `chk(ovr_q[0].pullup_en, 1'b1)
        @(posedge clk_sys);
        ce <= 1'b1;
        step(3);
        `chk(pad_din_en_q, 8'hff)
        `chk(ovr_q[0].pullup_en, 1'b0)
        $display("test sleep hold done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (11) @(posedge clk_sys);
        #1;
        `chk(ovr_q, {8{PAOVR_OVR_NONE}})
        `chk(pad_drive_en_q, 8'h00)
        @(posedge clk_sys);
        rst <= 1'b0;
        t_cmp();
        t_reset_pin();
        t_ext_clk();
        t_pin_change();
        t_sleep_hold();
        conclude();
    end

    // all tests need well under 200 cycles
    initial begin
        repeat (2000) @(posedge clk_sys);
        mismatches++;
        conclude();
    end
endmodule
